// ===== src/sli_led_ctrl.sv
/*
 * Front-panel status LED controller: five LEDs for power, satellite signal,
 * wireless LAN, positioning and data service.
 * Assumes status inputs are synchronous to clk; LED outputs are active high.
 */
`default_nettype none

// How it works
// RULE1 - All LEDs solid for 15 s after power-up
// RULE2 - Power LED follows boot state patterns
// RULE3 - Signal LED: off 0, blink 1-2, solid 3-5
// RULE4 - Fix LED: off none, blink 2D/DR, solid 3D
// RULE5 - Data service LED solid when enabled, else off
// RULE6 - Wireless LED solid when enabled, else off

module sli_led_ctrl #(
    parameter logic [31:0] HOLD_CYCLES = 32'(sli_pkg::STARTUP_HOLD_CYC),
    parameter logic [31:0] TICK_CYCLES = 32'(sli_pkg::BLINK_TICK_CYC)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Device status
    input wire sli_pkg::sli_boot_t boot_state,
    input wire logic sat_link_en,
    input wire logic [sli_pkg::SAT_LVL_W-1:0] sat_level,
    input wire logic wlan_en,
    input wire sli_pkg::sli_fix_t fix_type,
    input wire logic data_service_en,
    // LEDs
    output logic power_indicator_led,
    output logic sat_signal_led,
    output logic wlan_led,
    output logic gnss_led,
    output logic data_service_led,
    // Sequence status
    output logic startup_done
);
    import sli_pkg::*;

    // ==========================================================
    // Pattern mapping functions
    // ==========================================================
    // Boot state to power LED pattern
    function automatic sli_pat_t boot_to_pat(input sli_boot_t b);
        sli_pat_t p;
        p = PAT_OFF;
        unique case (b)
            BOOT_OFF: p = PAT_OFF;
            BOOT_RECOVERY: p = PAT_DOUBLE;
            BOOT_STARTING: p = PAT_BLINK;
            BOOT_FALLBACK: p = PAT_RAPID;
            BOOT_READY: p = PAT_SOLID;
            default: p = PAT_OFF;         // Undefined codes stay dark
        endcase
        return p;
    endfunction

    // Fix type to positioning LED pattern
    function automatic sli_pat_t fix_to_pat(input sli_fix_t f);
        sli_pat_t p;
        p = PAT_OFF;
        unique case (f)
            FIX_DISABLED, FIX_NONE, FIX_TIME_ONLY: p = PAT_OFF;
            FIX_DEAD_RECKON, FIX_2D: p = PAT_BLINK;
            FIX_3D: p = PAT_SOLID;
            default: p = PAT_OFF;         // Undefined codes stay dark
        endcase
        return p;
    endfunction

    // Pattern to LED level for this cycle
    function automatic logic pat_level(input sli_pat_t p, input logic bl, input logic db,
                                       input logic rb);
        logic lv;
        lv = 1'b0;
        unique case (p)
            PAT_OFF: lv = 1'b0;
            PAT_SOLID: lv = 1'b1;
            PAT_BLINK: lv = bl;
            PAT_DOUBLE: lv = db;
            PAT_RAPID: lv = rb;
        endcase
        return lv;
    endfunction

    // ==========================================================
    // Declarations
    // ==========================================================
    sli_state_t st_q;                   // Hold or run
    sli_state_t st_d;
    logic [31:0] hold_cnt_q;            // Cycles spent in hold, frozen at the end
    logic [31:0] hold_cnt_d;
    logic hold_end_w;                   // Last cycle of the all-on hold
    logic blink_w;                      // Shared waveforms
    logic dbl_w;
    logic rapid_w;
    sli_pat_t pwr_pat_w;                // Pattern choices
    sli_pat_t sat_pat_w;
    sli_pat_t gnss_pat_w;
    logic sat_blink_w;                  // Signal level band decode
    logic sat_solid_w;
    logic [4:0] led_run_w;              // LED levels in normal running
    logic [4:0] led_d;
    logic [4:0] led_q;                  // Registered LED drive

    // ==========================================================
    // Blink waveforms
    // ==========================================================
    sli_pattern_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_pattern (
        .clk(clk),
        .reset_n(reset_n),
        .blink(blink_w),
        .double_blink(dbl_w),
        .rapid_blink(rapid_w)
    );

    // ==========================================================
    // Startup hold sequence
    // ==========================================================
    assign hold_end_w = (hold_cnt_q == HOLD_CYCLES - 32'h1);
    assign hold_cnt_d = (st_q == ST_HOLD && !hold_end_w) ? hold_cnt_q + 32'h1 : hold_cnt_q;
    assign st_d = (st_q == ST_HOLD && hold_end_w) ? ST_RUN : st_q; // RULE1

    // State and hold counter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q <= ST_HOLD;
            hold_cnt_q <= CNT_RST;
        end else begin
            st_q <= st_d;
            hold_cnt_q <= hold_cnt_d;
        end
    end

    // ==========================================================
    // Status decode
    // ==========================================================
    assign pwr_pat_w = boot_to_pat(boot_state); // RULE2
    // Levels above the top band are clamped to solid
    assign sat_solid_w = sat_link_en && (sat_level >= SAT_LVL_SOLID_MIN); // RULE3
    assign sat_blink_w = sat_link_en && (sat_level >= SAT_LVL_BLINK_MIN) && !sat_solid_w; // RULE3
    assign sat_pat_w = sat_solid_w ? PAT_SOLID : (sat_blink_w ? PAT_BLINK : PAT_OFF); // RULE3
    assign gnss_pat_w = fix_to_pat(fix_type); // RULE4

    // LED order: data, gnss, wlan, sat, power
    assign led_run_w[0] = pat_level(pwr_pat_w, blink_w, dbl_w, rapid_w); // RULE2
    assign led_run_w[1] = pat_level(sat_pat_w, blink_w, dbl_w, rapid_w); // RULE3
    assign led_run_w[2] = wlan_en; // RULE6
    assign led_run_w[3] = pat_level(gnss_pat_w, blink_w, dbl_w, rapid_w); // RULE4
    assign led_run_w[4] = data_service_en; // RULE5

    // All LEDs forced on during the hold
    assign led_d = (st_q == ST_HOLD) ? LEDS_ALL_ON : led_run_w; // RULE1

    // ==========================================================
    // LED output registers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            led_q <= LEDS_ALL_ON;
        end else begin
            led_q <= led_d;
        end
    end

    assign power_indicator_led = led_q[0];
    assign sat_signal_led = led_q[1];
    assign wlan_led = led_q[2];
    assign gnss_led = led_q[3];
    assign data_service_led = led_q[4];
    assign startup_done = (st_q == ST_RUN);

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Expected LED levels restated from the status rules, so the checks
    // below can look one cycle back at a single signal
    logic pwr_exp_w;
    logic sat_exp_w;
    logic gnss_exp_w;
    assign pwr_exp_w = (boot_state == BOOT_READY) ||
        (boot_state == BOOT_STARTING && blink_w) ||
        (boot_state == BOOT_RECOVERY && dbl_w) ||
        (boot_state == BOOT_FALLBACK && rapid_w);
    assign sat_exp_w = (sat_link_en && sat_level >= 3'h3) ||
        (sat_link_en && sat_level != 3'h0 && sat_level < 3'h3 && blink_w);
    assign gnss_exp_w = (fix_type == FIX_3D) ||
        ((fix_type == FIX_2D || fix_type == FIX_DEAD_RECKON) && blink_w);

    hold_all_on_a: assert property ( // RULE1
        st_q == ST_HOLD |=> led_q == LEDS_ALL_ON
    ) else $error("LED not lit during startup hold");

    hold_length_a: assert property ( // RULE1
        $rose(startup_done) |-> $past(hold_cnt_q) == HOLD_CYCLES - 32'h1
    ) else $error("Startup hold ended at the wrong count");

    run_stays_a: assert property ( // RULE1
        st_q == ST_RUN |=> st_q == ST_RUN
    ) else $error("Left run state without reset");

    power_led_a: assert property ( // RULE2
        st_q == ST_RUN |=> power_indicator_led == $past(pwr_exp_w)
    ) else $error("Power LED does not match boot state");

    sat_led_a: assert property ( // RULE3
        st_q == ST_RUN && sat_link_en && sat_level >= 3'h1 && sat_level <= 3'h2
        |=> sat_signal_led == $past(blink_w)
    ) else $error("Signal LED not blinking for low level");

    sat_solid_off_a: assert property ( // RULE3
        st_q == ST_RUN |=> sat_signal_led == $past(sat_exp_w)
    ) else $error("Signal LED wrong for level");

    gnss_led_a: assert property ( // RULE4
        st_q == ST_RUN |=> gnss_led == $past(gnss_exp_w)
    ) else $error("Positioning LED wrong for fix type");

    data_led_a: assert property ( // RULE5
        st_q == ST_RUN ##1 st_q == ST_RUN |-> data_service_led == $past(data_service_en)
    ) else $error("Data service LED does not follow enable");

    wlan_led_a: assert property ( // RULE6
        st_q == ST_RUN |=> wlan_led == $past(wlan_en)
    ) else $error("Wireless LED does not follow enable");

    hold_to_run_c: cover property ($rose(startup_done));
    recovery_blink_c: cover property (st_q == ST_RUN && boot_state == BOOT_RECOVERY
        ##1 power_indicator_led ##1 !power_indicator_led);
    sat_blink_c: cover property (st_q == ST_RUN && sat_blink_w ##1 sat_signal_led);
    fix_3d_c: cover property (st_q == ST_RUN && fix_type == FIX_3D ##1 gnss_led);

endmodule

`default_nettype wire

// ===== common/sli_pkg.sv
/*
 * Shared constants and types for the front-panel status LED driver.
 * Assumes a single 250 MHz system clock and status inputs that are already
 * synchronous to it.
 */
`default_nettype none

package sli_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam longint unsigned CLK_HZ = 64'd250_000_000;    // System clock rate
    localparam longint unsigned STARTUP_HOLD_S = 64'd15;     // All-on time after power-up
    localparam longint unsigned STARTUP_HOLD_CYC = STARTUP_HOLD_S * CLK_HZ;
    localparam longint unsigned BLINK_TICK_MS = 64'd125;     // One phase of the blink sequencer
    localparam longint unsigned BLINK_TICK_CYC = (BLINK_TICK_MS * CLK_HZ) / 64'd1000;

    // ==========================================================
    // Blink sequencer
    // ==========================================================
    localparam int PHASE_W = 3;                               // Eight phases, one second
    localparam logic [7:0] DBL_MASK = 8'h05;                  // Two short flashes per second
    localparam logic [PHASE_W-1:0] PHASE_RST = 3'h0;
    localparam logic [31:0] CNT_RST = 32'h0;
    localparam logic [4:0] LEDS_ALL_ON = 5'h1f;               // Every LED lit in reset and hold

    // ==========================================================
    // Signal level thresholds
    // ==========================================================
    localparam int SAT_LVL_W = 3;
    localparam logic [SAT_LVL_W-1:0] SAT_LVL_BLINK_MIN = 3'h1;
    localparam logic [SAT_LVL_W-1:0] SAT_LVL_SOLID_MIN = 3'h3;
    localparam logic [SAT_LVL_W-1:0] SAT_LVL_MAX = 3'h5;

    // ==========================================================
    // Types
    // ==========================================================
    // Device boot state, driven by the system controller
    typedef enum logic [2:0] {
        BOOT_OFF = 3'h0,
        BOOT_RECOVERY = 3'h1,
        BOOT_STARTING = 3'h2,
        BOOT_FALLBACK = 3'h3,
        BOOT_READY = 3'h4
    } sli_boot_t;

    // Positioning fix type
    typedef enum logic [2:0] {
        FIX_DISABLED = 3'h0,
        FIX_NONE = 3'h1,
        FIX_TIME_ONLY = 3'h2,
        FIX_DEAD_RECKON = 3'h3,
        FIX_2D = 3'h4,
        FIX_3D = 3'h5
    } sli_fix_t;

    // LED pattern selection
    typedef enum logic [4:0] {
        PAT_OFF = 5'h01,
        PAT_SOLID = 5'h02,
        PAT_BLINK = 5'h04,
        PAT_DOUBLE = 5'h08,
        PAT_RAPID = 5'h10
    } sli_pat_t;

    // Top-level sequence
    typedef enum logic [1:0] {
        ST_HOLD = 2'h1,
        ST_RUN = 2'h2
    } sli_state_t;

endpackage

`default_nettype wire

// ===== src/sli_pattern_gen.sv
/*
 * Blink waveform generator: slow blink, double blink and rapid blink.
 * Assumes one clock and a synchronous active-low reset; all three waves
 * share one phase counter so they stay aligned to each other.
 */
`default_nettype none

module sli_pattern_gen #(
    parameter logic [31:0] TICK_CYCLES = 32'(sli_pkg::BLINK_TICK_CYC)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Waveforms
    output logic blink,
    output logic double_blink,
    output logic rapid_blink
);
    import sli_pkg::*;

    // ==========================================================
    // Phase sequencer
    // ==========================================================
    logic [31:0] tick_cnt_q;            // Cycles within a phase
    logic [31:0] tick_cnt_d;
    logic [PHASE_W-1:0] phase_q;        // Current phase of eight
    logic [PHASE_W-1:0] phase_d;
    logic tick_end_w;                   // Last cycle of a phase
    logic blink_q;
    logic dbl_q;
    logic rapid_q;

    assign tick_end_w = (tick_cnt_q == TICK_CYCLES - 32'h1);
    assign tick_cnt_d = tick_end_w ? CNT_RST : tick_cnt_q + 32'h1;
    assign phase_d = tick_end_w ? phase_q + 3'h1 : phase_q;

    // Counters and registered waveforms
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tick_cnt_q <= CNT_RST;
            phase_q <= PHASE_RST;
            blink_q <= 1'b0;
            dbl_q <= 1'b0;
            rapid_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            phase_q <= phase_d;
            blink_q <= ~phase_d[PHASE_W-1];
            dbl_q <= DBL_MASK[phase_d];
            rapid_q <= ~phase_d[0];
        end
    end

    assign blink = blink_q;
    assign double_blink = dbl_q;
    assign rapid_blink = rapid_q;

endmodule

`default_nettype wire

// ===== src/sli_led_ctrl_unused_placeholder_removed.sv
/*
 * Holds no module of its own; the LED driver lives in its two sibling files.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
`default_nettype wire

// ===== test/sli_led_ctrl_tb_top.sv
/*
 * Self-checking bench for the front-panel status LED controller.
 * Assumes short sim counts: hold of 50 cycles, blink phase of 4 cycles,
 * so one blink period spans 32 cycles.
 */
`default_nettype none

module sli_led_ctrl_tb_top import sli_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals and design
    // ==========================================================
    localparam logic [31:0] HOLD = 32'h32; // Short all-on hold
    localparam int LP = 4, LS = 3, LW = 2, LG = 1, LD = 0; // LED bit positions
    logic clk, reset_n, sat_link_en, wlan_en, data_service_en, startup_done;
    logic [SAT_LVL_W-1:0] sat_level;
    sli_boot_t boot_state;
    sli_fix_t fix_type;
    logic pwr_l, sat_l, wlan_l, gnss_l, data_l;
    wire logic [4:0] leds = {pwr_l, sat_l, wlan_l, gnss_l, data_l};
    int err_count = 0;
    int checks_done = 0;
    logic [4:0] p [5]; // Measured pattern of each LED

    sli_led_ctrl #(.HOLD_CYCLES(HOLD), .TICK_CYCLES(32'h4)) i_sli_led_ctrl (
        .clk(clk), .reset_n(reset_n), .boot_state(boot_state),
        .sat_link_en(sat_link_en), .sat_level(sat_level), .wlan_en(wlan_en),
        .fix_type(fix_type), .data_service_en(data_service_en),
        .power_indicator_led(pwr_l), .sat_signal_led(sat_l), .wlan_led(wlan_l),
        .gnss_led(gnss_l), .data_service_led(data_l), .startup_done(startup_done));

    // Free-running clock, 4 ns period
    always #2 clk = ~clk;

    // ==========================================================
    // Compare, measure and report helpers
    // ==========================================================
    task automatic chk_bits(input logic [5:0] got, input logic [5:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pat(input logic [4:0] got, input logic [4:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s: pattern %h expected %h", $time, what, got, exp);
        end
    endtask

    // Name a pattern from on-cycles and rising edges over one period
    function automatic logic [4:0] pat_of(input int on, input int rise);
        if (on == 0) return PAT_OFF;
        if (on == 32) return PAT_SOLID;
        if (on == 16 && rise == 1) return PAT_BLINK;
        if (on == 8 && rise == 2) return PAT_DOUBLE;
        if (on == 16 && rise == 4) return PAT_RAPID;
        return 5'h00;
    endfunction

    // Let inputs settle, then watch every LED for one full period
    task automatic measure();
        int on [5];
        int rise [5];
        logic [4:0] prev;
        logic [4:0] cur;
        on = '{default: 0};
        rise = '{default: 0};
        repeat (6) @(posedge clk);
        #1 prev = leds;
        for (int c = 0; c < 32; c++) begin
            @(posedge clk);
            #1 cur = leds;
            for (int b = 0; b < 5; b++) begin
                on[b] += int'(cur[b] === 1'b1);
                rise[b] += int'(prev[b] !== 1'b1 && cur[b] === 1'b1);
            end
            prev = cur;
        end
        for (int b = 0; b < 5; b++) p[b] = pat_of(on[b], rise[b]);
    endtask

    task automatic final_report();
        $display("Checks made: %0d, mismatches: %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // After reset release: all LEDs lit, then bounded wait for run state
    task automatic watch_hold();
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            #1 chk_bits({leds, startup_done}, 6'h3e, "hold");
        end
        while (startup_done !== 1'b1 && n < 120) begin
            @(posedge clk);
            n++;
        end
        if (startup_done !== 1'b1) begin
            err_count++;
            $display("BAD %0t startup never ended", $time);
            final_report();
        end
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic test_hold();
        @(posedge clk) reset_n <= 1'b1;
        watch_hold();
        measure();
        chk_bits({leds, startup_done}, 6'h01, "all off after hold");
        $display("test_hold done");
    endtask

    task automatic test_power();
        // Codes past ready are undefined and must leave the LED dark
        logic [4:0] exp [8] = '{PAT_OFF, PAT_DOUBLE, PAT_BLINK, PAT_RAPID, PAT_SOLID,
            PAT_OFF, PAT_OFF, PAT_OFF};
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) boot_state <= sli_boot_t'(i);
            measure();
            chk_pat(p[LP], exp[i], "power led");
        end
        $display("test_power done");
    endtask

    task automatic test_sat();
        // Levels above the top band are clamped to solid
        logic [4:0] exp [8] = '{PAT_OFF, PAT_BLINK, PAT_BLINK, PAT_SOLID, PAT_SOLID, PAT_SOLID,
            PAT_SOLID, PAT_SOLID};
        @(posedge clk) sat_level <= SAT_LVL_MAX;
        measure();
        chk_pat(p[LS], PAT_OFF, "signal led disabled");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) sat_link_en <= 1'b1;
            sat_level <= 3'(i);
            measure();
            chk_pat(p[LS], exp[i], "signal led level");
        end
        $display("test_sat done");
    endtask

    task automatic test_fix();
        // Codes past a 3D fix are undefined and must leave the LED dark
        logic [4:0] exp [8] = '{PAT_OFF, PAT_OFF, PAT_OFF, PAT_BLINK, PAT_BLINK, PAT_SOLID,
            PAT_OFF, PAT_OFF};
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) fix_type <= sli_fix_t'(i);
            measure();
            chk_pat(p[LG], exp[i], "fix led");
        end
        $display("test_fix done");
    endtask

    task automatic test_onoff();
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk) wlan_en <= 1'(i);
            data_service_en <= 1'(i);
            measure();
            chk_pat(p[LD], i ? PAT_SOLID : PAT_OFF, "data service led");
            chk_pat(p[LW], i ? PAT_SOLID : PAT_OFF, "wireless led");
        end
        $display("test_onoff done");
    endtask

    task automatic test_rerun();
        @(posedge clk) reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk_bits({leds, startup_done}, 6'h3e, "in reset");
        @(posedge clk) reset_n <= 1'b1;
        watch_hold();
        $display("test_rerun done");
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        boot_state = BOOT_OFF;
        sat_link_en = 1'b0;
        sat_level = 3'h0;
        wlan_en = 1'b0;
        fix_type = FIX_DISABLED;
        data_service_en = 1'b0;
        repeat (10) @(posedge clk);
        test_hold();
        test_power();
        test_sat();
        test_fix();
        test_onoff();
        test_rerun();
        final_report();
    end
endmodule

`default_nettype wire
